// >>> dv/obl_flash_model.sv
`default_nettype none

module obl_flash_model
  import obl_pkg::*;
(
  input wire logic pclk,
  input wire logic flash_rd_req,
  input wire logic [15:0] flash_rd_addr,
  input wire logic [7:0] opt,
  input wire logic [3:0] lat,
  output logic [7:0] flash_rd_data,
  output logic flash_rd_valid
);
  logic [3:0] cnt = '0;
  initial flash_rd_data = 8'h00;
  initial flash_rd_valid = 1'b0;
  // ----------------------------------------
  // Byte fetch, answered lat+1 cycles after the request is first seen
  // ----------------------------------------
  always @(posedge pclk) begin
    if (flash_rd_req !== 1'b1 || flash_rd_valid) begin
      cnt <= '0;
      flash_rd_valid <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
    end else if (cnt >= lat) begin
      flash_rd_valid <= 1'b1;
      flash_rd_data <= (flash_rd_addr == OBL_USER_OPT_ADDR) ? opt : OBL_OPT_ERASED;
    end else begin
      cnt <= cnt + 4'h1;
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule

`default_nettype wire

// >>> dv/obl_loader_properties.sv
`default_nettype none

module obl_loader_properties
  import obl_pkg::*;
#(
  parameter int FLASH_KB = 64,
  parameter int HIGH_SECTOR_KB = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic short_reset_req,
  input wire logic stop_recovery_req,
  input wire logic flash_rd_req,
  input wire logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic cpu_hold_reset,
  input wire logic watchdog_timeout_reset_select,
  input wire logic watchdog_always_on_n,
  input wire logic code_read_protect_n,
  input wire logic high_sector_write_allow,
  input wire logic global_write_allow,
  input wire logic watchdog_start_instruction,
  input wire logic watchdog_timeout,
  input wire logic watchdog_running,
  input wire logic watchdog_irq_req,
  input wire logic watchdog_short_reset,
  input wire logic dbg_mass_erase_req,
  input wire logic flash_prog_strobe,
  input wire logic flash_page_erase_strobe,
  input wire logic flash_mass_erase_strobe,
  input wire logic [15:0] flash_op_addr
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam int HS_PAGE = (FLASH_KB - HIGH_SECTOR_KB) * OBL_PAGES_PER_KB;
  logic [4:0] opts;
  logic [7:0] data_q;
  assign opts = {watchdog_timeout_reset_select, watchdog_always_on_n, code_read_protect_n,
    high_sector_write_allow, global_write_allow};
  always_ff @(posedge pclk) data_q <= flash_rd_data;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fetch_done;
    flash_rd_req && flash_rd_valid && !short_reset_req && !stop_recovery_req;
  endsequence
  sequence s_loaded;
    !cpu_hold_reset && !flash_rd_req && opts == {data_q[7:6], data_q[2:0]};
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reload;
    short_reset_req || stop_recovery_req |-> ##[1:2] flash_rd_req && cpu_hold_reset;
  endproperty
  a_reload: assert property (p_reload) else $error("reset did not restart load");
  property p_hold;
    cpu_hold_reset && flash_rd_req && !flash_rd_valid |=> cpu_hold_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("hold released before load");
  property p_load;
    s_fetch_done |=> s_loaded;
  endproperty
  a_load: assert property (p_load) else $error("options not taken from fetched byte");
  property p_addr;
    flash_rd_req |-> flash_rd_addr == OBL_USER_OPT_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("option fetch from wrong address");
  property p_stable;
    !flash_rd_req |=> flash_rd_req || $stable(opts);
  endproperty
  a_stable: assert property (p_stable) else $error("options changed outside load");
  property p_ao;
    $fell(cpu_hold_reset) && !watchdog_always_on_n |-> ##[0:1] watchdog_running;
  endproperty
  a_ao: assert property (p_ao) else $error("watchdog not on after load");
  property p_start;
    watchdog_start_instruction && !cpu_hold_reset && !flash_rd_req && !short_reset_req
      && !stop_recovery_req && !watchdog_timeout && !watchdog_short_reset |=> watchdog_running;
  endproperty
  a_start: assert property (p_start) else $error("watchdog did not start");
  property p_res;
    watchdog_running && watchdog_timeout && !cpu_hold_reset && !short_reset_req && !stop_recovery_req
      && !watchdog_short_reset |=>
      watchdog_short_reset == $past(watchdog_timeout_reset_select)
      && watchdog_irq_req != $past(watchdog_timeout_reset_select);
  endproperty
  a_res: assert property (p_res) else $error("wrong timeout response");
  property p_prot;
    flash_prog_strobe || flash_page_erase_strobe |->
      global_write_allow || (high_sector_write_allow && int'(flash_op_addr[15:9]) >= HS_PAGE);
  endproperty
  a_prot: assert property (p_prot) else $error("protected write started");
  property p_mass;
    flash_mass_erase_strobe |-> global_write_allow || $past(dbg_mass_erase_req);
  endproperty
  a_mass: assert property (p_mass) else $error("protected mass erase started");
endmodule

bind obl_loader obl_loader_properties #(.FLASH_KB(FLASH_KB), .HIGH_SECTOR_KB(HIGH_SECTOR_KB)) i_props (
  .pclk(pclk), .presetn(presetn), .short_reset_req(short_reset_req), .stop_recovery_req(stop_recovery_req),
  .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
  .flash_rd_valid(flash_rd_valid), .cpu_hold_reset(cpu_hold_reset),
  .watchdog_timeout_reset_select(watchdog_timeout_reset_select), .watchdog_always_on_n(watchdog_always_on_n),
  .code_read_protect_n(code_read_protect_n), .high_sector_write_allow(high_sector_write_allow),
  .global_write_allow(global_write_allow), .watchdog_start_instruction(watchdog_start_instruction),
  .watchdog_timeout(watchdog_timeout), .watchdog_running(watchdog_running), .watchdog_irq_req(watchdog_irq_req),
  .watchdog_short_reset(watchdog_short_reset), .dbg_mass_erase_req(dbg_mass_erase_req),
  .flash_prog_strobe(flash_prog_strobe), .flash_page_erase_strobe(flash_page_erase_strobe),
  .flash_mass_erase_strobe(flash_mass_erase_strobe), .flash_op_addr(flash_op_addr)
);

`default_nettype wire

// >>> dv/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import obl_pkg::*;
  localparam int FKB = 64;
  localparam int HKB = 4;
  localparam logic [6:0] HSP = 7'((FKB - HKB) * OBL_PAGES_PER_KB);
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, req, vld, hold, ps, pes, mes, irq, wsr, wrun;
  logic [4:0] pl = '0, ov;
  logic [15:0] rda, oa;
  logic [7:0] rdd, od, opt = 8'hFF;
  logic [3:0] lat = 4'h2;
  int fail_count = 0, n_tests = 0, pe_cnt = 0, me_cnt = 0, ps_cnt = 0, irq_cnt = 0, sr_cnt = 0;
  // Reserved bits 5..3 kept at one
  logic [7:0] tbl [4] = '{8'h38, 8'hBA, 8'h79, 8'hFF};

  obl_loader #(.FLASH_KB(FKB), .HIGH_SECTOR_KB(HKB)) i_obl_loader (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .short_reset_req(pl[0]),
    .stop_recovery_req(pl[1]), .flash_rd_req(req), .flash_rd_addr(rda), .flash_rd_data(rdd),
    .flash_rd_valid(vld), .cpu_hold_reset(hold), .watchdog_timeout_reset_select(ov[4]),
    .watchdog_always_on_n(ov[3]), .code_read_protect_n(ov[2]), .high_sector_write_allow(ov[1]),
    .global_write_allow(ov[0]), .watchdog_start_instruction(pl[2]), .watchdog_timeout(pl[3]),
    .watchdog_running(wrun), .watchdog_irq_req(irq), .watchdog_short_reset(wsr), .dbg_mass_erase_req(pl[4]),
    .flash_prog_strobe(ps), .flash_page_erase_strobe(pes), .flash_mass_erase_strobe(mes),
    .flash_op_addr(oa), .flash_op_data(od)
  );
  obl_flash_model i_obl_flash_model (
    .pclk(pclk), .flash_rd_req(req), .flash_rd_addr(rda), .opt(opt), .lat(lat),
    .flash_rd_data(rdd), .flash_rd_valid(vld)
  );

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (ps === 1'b1) ps_cnt <= ps_cnt + 1;
    if (pes === 1'b1) pe_cnt <= pe_cnt + 1;
    if (mes === 1'b1) me_cnt <= me_cnt + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (wsr === 1'b1) sr_cnt <= sr_cnt + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, x);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge pclk);
    pl[k] <= 1'b1;
    @(posedge pclk);
    pl <= '0;
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (hold !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) fail_count++;
  endtask
  // Command 00 stands for a byte program at the page's offset 0C3
  task automatic fop(input logic [7:0] cmd, input logic [6:0] pg, input logic ok);
    int c;
    c = pe_cnt + me_cnt + ps_cnt;
    apb(1'b1, OBL_PAGE_OFFSET, {25'h0, pg});
    apb(1'b1, OBL_PADDR_OFFSET, {16'h0, pg, 9'h0C3});
    apb(1'b1, OBL_CMD_OFFSET, {24'h0, OBL_UNLOCK1});
    apb(1'b1, OBL_CMD_OFFSET, {24'h0, OBL_UNLOCK2});
    apb(1'b0, OBL_CMD_OFFSET, 32'h0);
    chk(r, 32'h2);
    if (cmd == 8'h00) apb(1'b1, OBL_PDATA_OFFSET, 32'h0000_005A);
    else apb(1'b1, OBL_CMD_OFFSET, {24'h0, cmd});
    apb(1'b0, OBL_STAT_OFFSET, 32'h0);
    chk(32'(r[0]), 32'(!ok));
    chk(32'(pe_cnt + me_cnt + ps_cnt - c), 32'(ok));
    if (ok && cmd != OBL_MASS_ERASE) chk({16'h0, oa}, {16'h0, pg, (cmd == 8'h00) ? 9'h0C3 : 9'h000});
    if (ok && cmd == 8'h00) chk(32'(od), 32'h5A);
    apb(1'b0, OBL_CMD_OFFSET, 32'h0);
    chk(r, (ok && cmd == 8'h00) ? 32'h2 : 32'h0);
    if (ok && cmd == 8'h00) apb(1'b1, OBL_CMD_OFFSET, 32'h0);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int c0, c1;
    repeat (8) @(posedge pclk);
    chk({26'h0, ov, hold}, 32'h3F);
    presetn <= 1'b1;
    wait_load();
    chk(32'(ov), 32'h1F);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OBL_CMD_OFFSET, {24'h0, OBL_UNLOCK1});
    apb(1'b0, OBL_CMD_OFFSET, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, OBL_CMD_OFFSET, {24'h0, OBL_PAGE_ERASE});
    apb(1'b0, OBL_CMD_OFFSET, 32'h0);
    chk(r, 32'h0);
    foreach (tbl[i]) begin
      opt <= tbl[i];
      lat <= 4'(3 * i + 1);
      pulse(i % 2);
      wait_load();
      chk(32'(ov), {27'h0, tbl[i][7:6], tbl[i][2:0]});
      apb(1'b0, OBL_STAT_OFFSET, 32'h0);
      chk(32'(r[2:1]), {31'h0, ~tbl[i][6]});
      fop(OBL_PAGE_ERASE, HSP - 7'h1, tbl[i][0]);
      fop(OBL_PAGE_ERASE, HSP, tbl[i][0] | tbl[i][1]);
      fop(OBL_MASS_ERASE, HSP, tbl[i][0]);
      fop(8'h00, HSP, tbl[i][0] | tbl[i][1]);
      fop(8'h00, HSP - 7'h1, tbl[i][0]);
      c0 = me_cnt;
      pulse(4);
      repeat (2) @(posedge pclk);
      chk(32'(me_cnt - c0), 32'h1);
      chk(32'(oa), 32'h0);
      if (tbl[i][6]) begin
        chk(32'(wrun), 32'h0);
        pulse(2);
        @(posedge pclk);
      end
      chk(32'(wrun), 32'h1);
      c0 = irq_cnt;
      c1 = sr_cnt;
      pulse(3);
      repeat (3) @(posedge pclk);
      chk(32'(irq_cnt - c0), 32'(!tbl[i][7]));
      chk(32'(sr_cnt - c1), 32'(tbl[i][7]));
      wait_load();
    end
    c0 = me_cnt;
    pulse(4);
    repeat (2) @(posedge pclk);
    chk(32'(me_cnt - c0), 32'h1);
    summarize();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire

// >>> logic/obl_loader.sv
`default_nettype none

module obl_loader
  import obl_pkg::*;
#(
  parameter int FLASH_KB = 64,
  parameter int HIGH_SECTOR_KB = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic short_reset_req,
  input wire logic stop_recovery_req,
  output logic flash_rd_req,
  output logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  output logic cpu_hold_reset,
  output logic watchdog_timeout_reset_select,
  output logic watchdog_always_on_n,
  output logic code_read_protect_n,
  output logic high_sector_write_allow,
  output logic global_write_allow,
  input wire logic watchdog_start_instruction,
  input wire logic watchdog_timeout,
  output logic watchdog_running,
  output logic watchdog_irq_req,
  output logic watchdog_short_reset,
  input wire logic dbg_mass_erase_req,
  output logic flash_prog_strobe,
  output logic flash_page_erase_strobe,
  output logic flash_mass_erase_strobe,
  output logic [15:0] flash_op_addr,
  output logic [7:0] flash_op_data
);

  // ----------------------------------------
  // Option load sequencer
  // ----------------------------------------
  obl_load_e ld_state, next_ld_state;
  logic [7:0] opt, next_opt;
  logic reload;

  // Watchdog short reset reloads too, like any other reset
  assign reload = short_reset_req | stop_recovery_req | watchdog_short_reset;

  always_comb begin
    next_ld_state = ld_state;
    next_opt = opt;
    if (reload) begin
      next_ld_state = OBL_LD_FETCH;
    end else begin
      unique case (ld_state)
        OBL_LD_FETCH: begin
          if (flash_rd_valid) begin
            next_opt = flash_rd_data;
            next_ld_state = OBL_LD_RUN;
          end
        end
        OBL_LD_RUN: begin
          next_ld_state = OBL_LD_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state <= OBL_LD_FETCH;
      opt <= OBL_OPT_ERASED;
    end else begin
      ld_state <= next_ld_state;
      opt <= next_opt;
    end
  end

  // ----------------------------------------
  // Flash read port and reset hold
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_rd_req <= 1'b1;
      flash_rd_addr <= OBL_USER_OPT_ADDR;
      cpu_hold_reset <= 1'b1;
    end else begin
      flash_rd_req <= (next_ld_state == OBL_LD_FETCH);
      flash_rd_addr <= OBL_USER_OPT_ADDR;
      cpu_hold_reset <= (next_ld_state == OBL_LD_FETCH);
    end
  end

  // ----------------------------------------
  // Option outputs, loaded only by the fetch
  // ----------------------------------------
  // No APB path reaches opt; the byte at 0001H is never fetched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_reset_select <= 1'b1;
      watchdog_always_on_n <= 1'b1;
      code_read_protect_n <= 1'b1;
      high_sector_write_allow <= 1'b1;
      global_write_allow <= 1'b1;
    end else begin
      watchdog_timeout_reset_select <= next_opt[OBL_TIMEOUT_RESET_BIT];
      watchdog_always_on_n <= next_opt[OBL_ALWAYS_ON_N_BIT];
      code_read_protect_n <= next_opt[OBL_READ_PROT_BIT];
      high_sector_write_allow <= next_opt[OBL_HS_ALLOW_BIT];
      global_write_allow <= next_opt[OBL_GLOBAL_ALLOW_BIT];
    end
  end

  // ----------------------------------------
  // Watchdog enable and time-out response
  // ----------------------------------------
  logic next_wd_running, next_wd_irq, next_wd_short;
  logic running_now;

  assign running_now = watchdog_running && ld_state == OBL_LD_RUN;

  always_comb begin
    next_wd_running = watchdog_running;
    next_wd_irq = 1'b0;
    next_wd_short = 1'b0;
    if (next_ld_state == OBL_LD_FETCH) begin
      next_wd_running = 1'b0;
    end else if (!next_opt[OBL_ALWAYS_ON_N_BIT]) begin
      next_wd_running = 1'b1;
    end else if (watchdog_start_instruction) begin
      next_wd_running = 1'b1;
    end
    if (running_now && watchdog_timeout && !reload) begin
      next_wd_short = opt[OBL_TIMEOUT_RESET_BIT];
      next_wd_irq = !opt[OBL_TIMEOUT_RESET_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_running <= 1'b0;
      watchdog_irq_req <= 1'b0;
      watchdog_short_reset <= 1'b0;
    end else begin
      watchdog_running <= next_wd_running;
      watchdog_irq_req <= next_wd_irq;
      watchdog_short_reset <= next_wd_short;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic setup, wr_access;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic mapped;
  obl_fc_e fc_state, next_fc_state;
  logic [6:0] page_sel, next_page_sel;
  logic [15:0] prog_addr, next_prog_addr;
  logic last_refused, next_last_refused;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite && !pslverr;
  assign mapped = paddr == OBL_CMD_OFFSET || paddr == OBL_PAGE_OFFSET || paddr == OBL_PADDR_OFFSET ||
                  paddr == OBL_STAT_OFFSET || paddr == OBL_PDATA_OFFSET;

  always_comb begin
    next_pready = setup;
    next_pslverr = setup && !mapped;
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (paddr == OBL_CMD_OFFSET) begin
        next_prdata = {26'h000_0000, fc_state};
      end else if (paddr == OBL_PAGE_OFFSET) begin
        next_prdata = {25'h000_0000, page_sel};
      end else if (paddr == OBL_PADDR_OFFSET) begin
        next_prdata = {16'h0000, prog_addr};
      end else if (paddr == OBL_STAT_OFFSET) begin
        next_prdata = {29'h0000_0000, ld_state == OBL_LD_FETCH, watchdog_running, last_refused};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Flash command sequencer with protection
  // ----------------------------------------
  obl_op_e guard_kind;
  logic [6:0] guard_page;
  logic guard_allow;
  logic cmd_wr, pdata_wr, busy_load;
  logic next_prog, next_perase, next_merase;
  logic [15:0] next_op_addr;
  logic [7:0] next_op_data;

  assign cmd_wr = wr_access && paddr == OBL_CMD_OFFSET;
  assign pdata_wr = wr_access && paddr == OBL_PDATA_OFFSET;
  assign busy_load = ld_state == OBL_LD_FETCH;

  always_comb begin
    guard_kind = OBL_OP_PROG;
    guard_page = prog_addr[15:OBL_PAGE_LSB];
    if (cmd_wr && pwdata[7:0] == OBL_PAGE_ERASE) begin
      guard_kind = OBL_OP_PAGE;
      guard_page = page_sel;
    end else if (cmd_wr) begin
      guard_kind = OBL_OP_MASS;
    end
  end

  obl_write_guard #(
    .FLASH_KB(FLASH_KB),
    .HIGH_SECTOR_KB(HIGH_SECTOR_KB)
  ) u_guard (
    .global_write_allow(global_write_allow),
    .high_sector_write_allow(high_sector_write_allow),
    .op_kind(guard_kind),
    .page(guard_page),
    .allow(guard_allow)
  );

  always_comb begin
    next_fc_state = fc_state;
    next_page_sel = page_sel;
    next_prog_addr = prog_addr;
    next_last_refused = last_refused;
    next_prog = 1'b0;
    next_perase = 1'b0;
    next_merase = 1'b0;
    next_op_addr = flash_op_addr;
    next_op_data = flash_op_data;
    if (wr_access && paddr == OBL_PAGE_OFFSET) begin
      next_page_sel = pwdata[6:0];
    end
    if (wr_access && paddr == OBL_PADDR_OFFSET) begin
      next_prog_addr = pwdata[15:0];
    end
    if (cmd_wr) begin
      next_fc_state = OBL_FC_LOCKED;
      unique case (fc_state)
        OBL_FC_LOCKED: begin
          if (pwdata[7:0] == OBL_UNLOCK1) begin
            next_fc_state = OBL_FC_FIRST;
          end
        end
        OBL_FC_FIRST: begin
          if (pwdata[7:0] == OBL_UNLOCK2) begin
            next_fc_state = OBL_FC_UNLOCKED;
          end
        end
        OBL_FC_UNLOCKED: begin
          if (pwdata[7:0] == OBL_PAGE_ERASE || pwdata[7:0] == OBL_MASS_ERASE) begin
            next_last_refused = !guard_allow || busy_load;
            next_perase = guard_allow && !busy_load && pwdata[7:0] == OBL_PAGE_ERASE;
            next_merase = guard_allow && !busy_load && pwdata[7:0] == OBL_MASS_ERASE;
            next_op_addr = {page_sel, 9'h000};
          end
        end
        default: begin
          next_fc_state = OBL_FC_LOCKED;
        end
      endcase
    end else if (pdata_wr && fc_state == OBL_FC_UNLOCKED) begin
      next_last_refused = !guard_allow || busy_load;
      if (guard_allow && !busy_load) begin
        next_prog = 1'b1;
        next_op_addr = prog_addr;
        next_op_data = pwdata[7:0];
      end else begin
        next_fc_state = OBL_FC_LOCKED;
      end
    end
    if (dbg_mass_erase_req) begin
      next_merase = 1'b1;
      next_op_addr = 16'h0000;
    end
    if (reload) begin
      next_fc_state = OBL_FC_LOCKED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_state <= OBL_FC_LOCKED;
      page_sel <= OBL_PAGE_RESET;
      prog_addr <= OBL_PADDR_RESET;
      last_refused <= 1'b0;
      flash_prog_strobe <= 1'b0;
      flash_page_erase_strobe <= 1'b0;
      flash_mass_erase_strobe <= 1'b0;
      flash_op_addr <= 16'h0000;
      flash_op_data <= 8'h00;
    end else begin
      fc_state <= next_fc_state;
      page_sel <= next_page_sel;
      prog_addr <= next_prog_addr;
      last_refused <= next_last_refused;
      flash_prog_strobe <= next_prog;
      flash_page_erase_strobe <= next_perase;
      flash_mass_erase_strobe <= next_merase;
      flash_op_addr <= next_op_addr;
      flash_op_data <= next_op_data;
    end
  end

endmodule

`default_nettype wire

// >>> logic/obl_pkg.sv
// Behaviour
// - Every reset type reloads option byte from flash
// - Hold processor reset until load completes
// - Option registers never visible to software
// - Use byte 0000H only; 0001H ignored
// - Bit 7 picks interrupt or short reset
// - Bit 6 clear forces watchdog always on
// - Bit 6 set: start by instruction, stop by reset
// - Bit 2 clear denies debugger code reads
// - Both protect bits clear refuse user writes
// - High-sector bit alone allows top sector only
// - Global bit set allows all program and erase
// - Two unlock codes then erase command or data write (program), else relock
// - Page erase uses seven-bit page select field
`default_nettype none

package obl_pkg;

  // ----------------------------------------
  // Option byte layout
  // ----------------------------------------
  localparam logic [15:0] OBL_USER_OPT_ADDR = 16'h0000;
  localparam logic [15:0] OBL_RSVD_OPT_ADDR = 16'h0001;
  localparam logic [7:0] OBL_OPT_ERASED = 8'hFF;
  localparam int OBL_TIMEOUT_RESET_BIT = 7;
  localparam int OBL_ALWAYS_ON_N_BIT = 6;
  localparam int OBL_READ_PROT_BIT = 2;
  localparam int OBL_HS_ALLOW_BIT = 1;
  localparam int OBL_GLOBAL_ALLOW_BIT = 0;

  // ----------------------------------------
  // APB register offsets
  // ----------------------------------------
  localparam logic [11:0] OBL_CMD_OFFSET = 12'h000;
  localparam logic [11:0] OBL_PAGE_OFFSET = 12'h004;
  localparam logic [11:0] OBL_PADDR_OFFSET = 12'h008;
  localparam logic [11:0] OBL_STAT_OFFSET = 12'h00C;
  localparam logic [11:0] OBL_PDATA_OFFSET = 12'h010;

  // ----------------------------------------
  // Flash command codes and geometry
  // ----------------------------------------
  localparam logic [7:0] OBL_UNLOCK1 = 8'h73;
  localparam logic [7:0] OBL_UNLOCK2 = 8'h8C;
  localparam logic [7:0] OBL_PAGE_ERASE = 8'h95;
  localparam logic [7:0] OBL_MASS_ERASE = 8'h63;
  localparam int OBL_PAGE_LSB = 9;
  localparam int OBL_PAGES_PER_KB = 2;
  localparam logic [6:0] OBL_PAGE_RESET = 7'h00;
  localparam logic [15:0] OBL_PADDR_RESET = 16'h0000;

  typedef enum logic [0:0] {
    OBL_LD_FETCH = 1'b0,
    OBL_LD_RUN = 1'b1
  } obl_load_e;

  typedef enum logic [5:0] {
    OBL_FC_LOCKED = 6'b000000,
    OBL_FC_FIRST = 6'b000001,
    OBL_FC_UNLOCKED = 6'b000010
  } obl_fc_e;

  typedef enum logic [1:0] {
    OBL_OP_PROG = 2'b00,
    OBL_OP_PAGE = 2'b01,
    OBL_OP_MASS = 2'b10
  } obl_op_e;

endpackage

`default_nettype wire

// >>> logic/obl_write_guard.sv
`default_nettype none

module obl_write_guard
  import obl_pkg::*;
#(
  parameter int FLASH_KB = 64,
  parameter int HIGH_SECTOR_KB = 4
) (
  input wire logic global_write_allow,
  input wire logic high_sector_write_allow,
  input wire obl_op_e op_kind,
  input wire logic [6:0] page,
  output logic allow
);

  // ----------------------------------------
  // High sector sits at the top of flash
  // ----------------------------------------
  localparam logic [7:0] FIRST_HS_PAGE =
    8'((FLASH_KB - HIGH_SECTOR_KB) * OBL_PAGES_PER_KB);

  always_comb begin
    if (global_write_allow) begin
      allow = 1'b1;
    end else if (high_sector_write_allow && op_kind != OBL_OP_MASS) begin
      allow = ({1'b0, page} >= FIRST_HS_PAGE);
    end else begin
      allow = 1'b0;
    end
  end

endmodule

`default_nettype wire
